/* rtl/psw_sequencer.sv */
// persistent switch sequencer top
`timescale 1ns/1ns
`default_nettype none
module persistent_switch_sequencer
	import psw_pkg::*;
#(
	parameter int TICK_CYCLES_P = psw_pkg::TICK_CYCLES,
	parameter int MISMATCH_S = psw_pkg::MISMATCH_SHOW_S
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// commands from keypad and remote link
	input wire psw_pkg::psw_keys_t keypad_keys,
	input wire psw_pkg::psw_keys_t remote_keys,
	// operating settings
	input wire logic [psw_pkg::SEC_W-1:0] switch_heat_duration,
	input wire logic [psw_pkg::SEC_W-1:0] switch_cool_duration,
	input wire logic [psw_pkg::CUR_W-1:0] switch_supply_ramp_rate,
	// ramping status from the supply control
	input wire logic holding_at_target,
	input wire logic [psw_pkg::CUR_W-1:0] magnet_current_ma,
	input wire logic [psw_pkg::CUR_W-1:0] supply_current_ma,
	input wire logic [psw_pkg::VOLT_W-1:0] magnet_voltage,
	input wire logic ramp_request,
	// retained memory
	input wire psw_pkg::psw_retained_t retained_in,
	output psw_pkg::psw_retained_t retained_out,
	output logic retained_write,
	// supply ramp command
	output logic ramp_enable,
	output logic [psw_pkg::CUR_W-1:0] ramp_target_ma,
	output logic [psw_pkg::CUR_W-1:0] ramp_rate,
	output logic ramp_request_granted,
	// status
	output psw_pkg::psw_state_t state,
	output logic heater_on,
	output logic persistent_indicator,
	output logic persistent_mode,
	output logic [psw_pkg::SEC_W-1:0] seconds_left,
	output logic switch_lock_error,
	output logic current_mismatch,
	output logic alert_pulse,
	output logic prompt_enter
);
	psw_state_t st_reg, st_next;
	logic heater_reg, heater_next;
	logic ind_reg, ind_next;
	logic pmode_reg, pmode_next;
	logic lock_reg, lock_next;
	logic mism_reg, mism_next;
	logic alert_reg, alert_next;
	logic wr_reg, wr_next;
	logic restored_reg, restored_next;
	logic [SEC_W-1:0] sec_reg, sec_next;
	logic [SEC_W-1:0] mism_sec_reg, mism_sec_next;
	logic [CUR_W-1:0] cooled_reg, cooled_next;
	logic [CUR_W-1:0] target_reg, target_next;
	logic ramp_en_reg, ramp_en_next;
	// set while a shifted-key interval runs, so its end takes no automatic step
	logic toggle_reg, toggle_next;
	logic tick;
	logic restart;
	logic k_sw, k_shift, k_enter, k_esc;
	logic vm_over;
	logic at_target;

	// ----------------------------------------
	// command merge and compares
	// ----------------------------------------
	assign k_sw = keypad_keys.switch_key | remote_keys.switch_key;
	assign k_shift = keypad_keys.shift_switch_key | remote_keys.shift_switch_key;
	assign k_enter = keypad_keys.enter | remote_keys.enter;
	assign k_esc = keypad_keys.escape | remote_keys.escape;
	assign vm_over = magnet_voltage > VM_LIMIT_MV;
	assign at_target = supply_current_ma == target_reg;

	// ----------------------------------------
	// one-second tick
	// ----------------------------------------
	// reloaded on every switch-interval countdown start (not on a mismatch set), so the first second is always whole
	psw_second_tick #(
		.CYCLES(TICK_CYCLES_P)
	) u_tick (
		.mclk(mclk),
		.rst(rst),
		.restart(restart),
		.tick(tick)
	);

	// ----------------------------------------
	// sequencer next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		heater_next = heater_reg;
		ind_next = ind_reg;
		pmode_next = pmode_reg;
		lock_next = lock_reg;
		alert_next = 1'b0;
		wr_next = 1'b0;
		restored_next = 1'b1;
		sec_next = sec_reg;
		cooled_next = cooled_reg;
		target_next = target_reg;
		ramp_en_next = ramp_en_reg;
		toggle_next = toggle_reg;
		restart = 1'b0;
		if (!restored_reg) begin
			// state is restored one cycle after reset, from retained memory
			heater_next = retained_in.heater_on;
			pmode_next = retained_in.persistent;
			cooled_next = retained_in.cooled_ma;
			st_next = retained_in.persistent ? ST_POWERUP_PROMPT : ST_PAUSED;
		end else begin
			unique case (st_reg)
				ST_PAUSED, ST_HOLDING: begin
					st_next = holding_at_target ? ST_HOLDING : ST_PAUSED;
					if (k_shift) begin
						// toggle only, but the interval still blocks ramping
						heater_next = !heater_reg;
						toggle_next = 1'b1;
						restart = 1'b1;
						sec_next = heater_reg ? switch_cool_duration : switch_heat_duration;
						st_next = heater_reg ? ST_COOLING : ST_HEATING;
						lock_next = 1'b0;
						wr_next = 1'b1;
					end else if (k_sw && !heater_reg) begin
						heater_next = 1'b1;
						restart = 1'b1;
						sec_next = switch_heat_duration;
						st_next = ST_HEATING;
						wr_next = 1'b1;
					end else if (k_sw && pmode_reg) begin
						st_next = ST_CONFIRM_EXIT;
					end else if (k_sw) begin
						st_next = ST_CONFIRM_ENTER;
					end
				end
				ST_CONFIRM_ENTER: begin
					if (k_esc) begin
						st_next = ST_PAUSED;
					end else if (k_enter) begin
						heater_next = 1'b0;
						cooled_next = magnet_current_ma;
						restart = 1'b1;
						sec_next = switch_cool_duration;
						st_next = ST_COOLING;
						lock_next = 1'b0;
					end
				end
				ST_HEATING, ST_COOLING, ST_LOCK_HEAT, ST_EXIT_HEAT: begin
					if (tick && sec_reg != '0) begin
						sec_next = sec_reg - SEC_W'(1);
					end
					if (sec_reg == '0) begin
						if (st_reg == ST_LOCK_HEAT) begin
							st_next = ST_PAUSED_ERR;
						end else if (st_reg == ST_EXIT_HEAT) begin
							pmode_next = 1'b0;
							ind_next = 1'b0;
							wr_next = 1'b1;
							st_next = ST_EXIT_DONE;
						end else if (toggle_reg) begin
							// a toggled interval ends without any automatic step
							toggle_next = 1'b0;
							st_next = ST_PAUSED;
						end else if (st_reg == ST_COOLING && !heater_reg) begin
							ind_next = cooled_reg > PERSIST_MIN_MA;
							target_next = '0;
							ramp_en_next = 1'b1;
							st_next = ST_RAMP_ZERO;
						end else begin
							st_next = ST_PAUSED;
						end
					end
				end
				ST_RAMP_ZERO: begin
					if (vm_over) begin
						ramp_en_next = 1'b0;
						alert_next = 1'b1;
						target_next = cooled_reg;
						st_next = ST_FAULT_MATCH;
					end else if (at_target) begin
						ramp_en_next = 1'b0;
						pmode_next = 1'b1;
						wr_next = 1'b1;
						st_next = ST_PERSIST;
					end
				end
				ST_FAULT_MATCH: begin
					ramp_en_next = 1'b1;
					if (ramp_en_reg && at_target) begin
						ramp_en_next = 1'b0;
						heater_next = 1'b1;
						lock_next = 1'b1;
						ind_next = 1'b0;
						restart = 1'b1;
						sec_next = switch_heat_duration;
						wr_next = 1'b1;
						st_next = ST_LOCK_HEAT;
					end
				end
				ST_PAUSED_ERR: begin
					if (k_enter) begin
						lock_next = 1'b0;
						st_next = ST_PAUSED;
					end
				end
				ST_PERSIST: begin
					if (k_sw) begin
						st_next = ST_CONFIRM_EXIT;
					end else if (k_shift) begin
						heater_next = 1'b1;
						toggle_next = 1'b1;
						restart = 1'b1;
						sec_next = switch_heat_duration;
						st_next = ST_HEATING;
						wr_next = 1'b1;
					end
				end
				ST_POWERUP_PROMPT: begin
					if (k_enter) begin
						ind_next = cooled_reg > PERSIST_MIN_MA;
						st_next = ST_PERSIST;
					end
				end
				ST_CONFIRM_EXIT: begin
					if (k_esc) begin
						st_next = ST_PERSIST;
					end else if (k_enter || k_sw) begin
						target_next = cooled_reg;
						ramp_en_next = 1'b1;
						st_next = ST_RAMP_MATCH;
					end
				end
				ST_RAMP_MATCH: begin
					if (ramp_en_reg && at_target) begin
						ramp_en_next = 1'b0;
						heater_next = 1'b1;
						restart = 1'b1;
						sec_next = switch_heat_duration;
						wr_next = 1'b1;
						st_next = ST_EXIT_HEAT;
					end
				end
				ST_EXIT_DONE: begin
					if (k_enter) begin
						st_next = ST_PAUSED;
					end
				end
				default: begin
					st_next = ST_PAUSED;
				end
			endcase
		end
		// a fresh mismatch beeps once, like the ramp fault
		if (mism_next && !mism_reg) begin
			alert_next = 1'b1;
		end
	end

	// ----------------------------------------
	// mismatch flag, shown for a fixed time
	// ----------------------------------------
	always_comb begin
		mism_next = mism_reg;
		mism_sec_next = mism_sec_reg;
		// voltage still over the limit reloads the timer, so the set beats the timeout
		if (st_reg == ST_EXIT_HEAT && vm_over) begin
			mism_next = 1'b1;
			mism_sec_next = SEC_W'(MISMATCH_S);
		end else if (mism_reg && tick) begin
			if (mism_sec_reg <= SEC_W'(1)) begin
				mism_next = 1'b0;
				mism_sec_next = '0;
			end else begin
				mism_sec_next = mism_sec_reg - SEC_W'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= ST_PAUSED;
			heater_reg <= 1'b0;
			ind_reg <= 1'b0;
			pmode_reg <= 1'b0;
			lock_reg <= 1'b0;
			mism_reg <= 1'b0;
			alert_reg <= 1'b0;
			wr_reg <= 1'b0;
			restored_reg <= 1'b0;
			sec_reg <= '0;
			mism_sec_reg <= '0;
			cooled_reg <= '0;
			target_reg <= '0;
			ramp_en_reg <= 1'b0;
			toggle_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			heater_reg <= heater_next;
			ind_reg <= ind_next;
			pmode_reg <= pmode_next;
			lock_reg <= lock_next;
			mism_reg <= mism_next;
			alert_reg <= alert_next;
			wr_reg <= wr_next;
			restored_reg <= restored_next;
			sec_reg <= sec_next;
			mism_sec_reg <= mism_sec_next;
			cooled_reg <= cooled_next;
			target_reg <= target_next;
			ramp_en_reg <= ramp_en_next;
			toggle_reg <= toggle_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign state = st_reg;
	assign heater_on = heater_reg;
	assign persistent_indicator = ind_reg;
	assign persistent_mode = pmode_reg;
	assign seconds_left = sec_reg;
	assign switch_lock_error = lock_reg;
	assign current_mismatch = mism_reg;
	assign alert_pulse = alert_reg;
	assign prompt_enter = st_reg == ST_CONFIRM_ENTER || st_reg == ST_CONFIRM_EXIT
		|| st_reg == ST_POWERUP_PROMPT || st_reg == ST_PAUSED_ERR || st_reg == ST_EXIT_DONE;
	assign ramp_enable = ramp_en_reg;
	assign ramp_target_ma = target_reg;
	assign ramp_rate = switch_supply_ramp_rate;
	// blocked while any switch interval runs
	assign ramp_request_granted = ramp_request && !(st_reg == ST_HEATING || st_reg == ST_COOLING
		|| st_reg == ST_LOCK_HEAT || st_reg == ST_EXIT_HEAT);
	// image written on every heater or persistent change, except the heater turning off on enter confirmation and the restore after reset
	assign retained_out = '{heater_on: heater_reg, persistent: pmode_reg, cooled_ma: cooled_reg};
	assign retained_write = wr_reg;
endmodule
`default_nettype wire

/* rtl/psw_pkg.sv */
// constants and types for the persistent switch sequencer
`default_nettype none
package psw_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_CYCLES = CLK_HZ;
	localparam int MISMATCH_SHOW_S = 15;
	localparam int SEC_W = 16;

	// ----------------------------------------
	// thresholds, in mA and mV
	// ----------------------------------------
	localparam int CUR_W = 24;
	localparam int VOLT_W = 16;
	localparam logic [CUR_W-1:0] PERSIST_MIN_MA = 24'h000064;
	localparam logic [VOLT_W-1:0] VM_LIMIT_MV = 16'h01f4;

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_PAUSED = 4'h0,
		ST_HOLDING = 4'h1,
		ST_HEATING = 4'h3,
		ST_CONFIRM_ENTER = 4'h2,
		ST_COOLING = 4'h6,
		ST_RAMP_ZERO = 4'h7,
		ST_PERSIST = 4'h5,
		ST_CONFIRM_EXIT = 4'h4,
		ST_RAMP_MATCH = 4'hc,
		ST_EXIT_HEAT = 4'hd,
		ST_EXIT_DONE = 4'hf,
		ST_FAULT_MATCH = 4'he,
		ST_LOCK_HEAT = 4'ha,
		ST_PAUSED_ERR = 4'hb,
		ST_POWERUP_PROMPT = 4'h9
	} psw_state_t;

	// ----------------------------------------
	// operator keys from one source
	// ----------------------------------------
	typedef struct packed {
		logic switch_key;
		logic shift_switch_key;
		logic enter;
		logic escape;
	} psw_keys_t;

	// ----------------------------------------
	// retained memory image
	// ----------------------------------------
	typedef struct packed {
		logic heater_on;
		logic persistent;
		logic [CUR_W-1:0] cooled_ma;
	} psw_retained_t;

endpackage
`default_nettype wire

/* rtl/psw_second_tick.sv */
// one-second tick generator
`timescale 1ns/1ns
`default_nettype none
module psw_second_tick #(
	parameter int CYCLES = psw_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// restart and tick
	input wire logic restart,
	output logic tick
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;

	always_comb begin
		if (restart || cnt_reg == 32'(CYCLES - 1)) begin
			cnt_next = 32'h0;
		end else begin
			cnt_next = cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_reg <= 32'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign tick = cnt_reg == 32'(CYCLES - 1);
endmodule
`default_nettype wire

/* dv/psw_keypad_model.sv */
// keypad and remote link model for the persistent switch sequencer
`timescale 1ns/1ns
`default_nettype none
module psw_keypad_model
	import psw_pkg::*;
(
	// clock
	input wire logic mclk,
	// key request from the bench
	input wire psw_pkg::psw_keys_t cmd,
	input wire logic use_remote,
	// key pulses toward the sequencer
	output psw_pkg::psw_keys_t keypad_keys,
	output psw_pkg::psw_keys_t remote_keys
);
	// one-cycle pulses, only one source active at a time
	always_ff @(posedge mclk) begin
		keypad_keys <= use_remote ? '0 : cmd;
		remote_keys <= use_remote ? cmd : '0;
	end
endmodule
`default_nettype wire

/* dv/psw_sequencer_sva.sv */
// assertions on the persistent switch sequencer ports
`timescale 1ns/1ns
`default_nettype none
module psw_sequencer_checker
	import psw_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// watched signals
	input wire psw_pkg::psw_keys_t keypad_keys,
	input wire psw_pkg::psw_keys_t remote_keys,
	input wire logic [psw_pkg::SEC_W-1:0] switch_cool_duration,
	input wire logic [psw_pkg::CUR_W-1:0] magnet_current_ma,
	input wire logic [psw_pkg::CUR_W-1:0] supply_current_ma,
	input wire logic [psw_pkg::VOLT_W-1:0] magnet_voltage,
	input wire psw_pkg::psw_retained_t retained_out,
	input wire logic ramp_enable,
	input wire logic [psw_pkg::CUR_W-1:0] ramp_target_ma,
	input wire logic ramp_request_granted,
	input wire psw_pkg::psw_state_t state,
	input wire logic heater_on,
	input wire logic persistent_indicator,
	input wire logic persistent_mode,
	input wire logic [psw_pkg::SEC_W-1:0] seconds_left,
	input wire logic switch_lock_error,
	input wire logic current_mismatch,
	input wire logic alert_pulse,
	input wire logic prompt_enter
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic enter_k, esc_k, vhigh;
	assign enter_k = keypad_keys.enter | remote_keys.enter;
	assign esc_k = keypad_keys.escape | remote_keys.escape;
	assign vhigh = magnet_voltage > VM_LIMIT_MV;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_confirm; state == ST_CONFIRM_ENTER && enter_k && !esc_k |=>
		state == ST_COOLING && !heater_on; endproperty
	a_confirm: assert property (p_confirm) else $error("enter confirmation did not start cooling");
	property p_prompt; state == ST_CONFIRM_ENTER |-> prompt_enter; endproperty
	a_prompt: assert property (p_prompt) else $error("no prompt while confirming");
	property p_cool; $changed(state) && state == ST_COOLING |-> seconds_left == switch_cool_duration; endproperty
	a_cool: assert property (p_cool) else $error("cooling count not loaded");
	property p_grant;
		state inside {ST_HEATING, ST_COOLING, ST_LOCK_HEAT, ST_EXIT_HEAT} |-> !ramp_request_granted;
	endproperty
	a_grant: assert property (p_grant) else $error("ramp granted during switch interval");
	property p_zero; state == ST_RAMP_ZERO |-> ramp_enable && ramp_target_ma == '0; endproperty
	a_zero: assert property (p_zero) else $error("ramp to zero not commanded");
	property p_ind; state == ST_RAMP_ZERO && $past(state) == ST_COOLING |->
		persistent_indicator == (retained_out.cooled_ma > PERSIST_MIN_MA); endproperty
	a_ind: assert property (p_ind) else $error("persistent indicator wrong");
	property p_vfault; state == ST_RAMP_ZERO && vhigh |=> state == ST_FAULT_MATCH && alert_pulse; endproperty
	a_vfault: assert property (p_vfault) else $error("voltage fault not handled");
	property p_lock; state == ST_LOCK_HEAT |-> switch_lock_error && heater_on; endproperty
	a_lock: assert property (p_lock) else $error("lock heating without error flag");
	property p_done; state == ST_RAMP_ZERO && supply_current_ma == '0 && !vhigh |=>
		state == ST_PERSIST && persistent_mode && !heater_on; endproperty
	a_done: assert property (p_done) else $error("persistent mode not reported");
	property p_match; state == ST_RAMP_MATCH |-> ramp_target_ma == retained_out.cooled_ma; endproperty
	a_match: assert property (p_match) else $error("match target not stored current");
	property p_mism; state == ST_EXIT_HEAT && vhigh |=> current_mismatch; endproperty
	a_mism: assert property (p_mism) else $error("mismatch not flagged");
	// ----------------------------------------
	// covers
	// ----------------------------------------
	c_persist: cover property (state == ST_PERSIST);
	c_lock: cover property (state == ST_LOCK_HEAT);
	c_exit: cover property (state == ST_EXIT_DONE);
	c_fault: cover property (state == ST_FAULT_MATCH && magnet_current_ma <= PERSIST_MIN_MA);
endmodule
bind persistent_switch_sequencer psw_sequencer_checker i_chk (.mclk(mclk), .rst(rst), .keypad_keys(keypad_keys),
	.remote_keys(remote_keys), .switch_cool_duration(switch_cool_duration), .magnet_current_ma(magnet_current_ma),
	.supply_current_ma(supply_current_ma), .magnet_voltage(magnet_voltage), .retained_out(retained_out),
	.ramp_enable(ramp_enable), .ramp_target_ma(ramp_target_ma), .ramp_request_granted(ramp_request_granted),
	.state(state), .heater_on(heater_on), .persistent_indicator(persistent_indicator),
	.persistent_mode(persistent_mode), .seconds_left(seconds_left), .switch_lock_error(switch_lock_error),
	.current_mismatch(current_mismatch), .alert_pulse(alert_pulse), .prompt_enter(prompt_enter));
`default_nettype wire

/* dv/test_persistent_switch_sequencer.sv */
// self-checking bench for the persistent switch sequencer
`timescale 1ns/1ns
`default_nettype none
module test_persistent_switch_sequencer;
	import psw_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [3:0] K_SW = 4'h8, K_SH = 4'h4, K_EN = 4'h2, K_ES = 4'h1;
	logic mclk, rst, use_remote, hold, rreq, r_wr, r_en, gnt, heat, ind, pmode, lock, mism, alert, prm;
	psw_keys_t cmd, kk, rk;
	logic [SEC_W-1:0] heat_s, cool_s, secs;
	logic [CUR_W-1:0] rate, mag_i, sup_i, tgt, r_rate;
	logic [VOLT_W-1:0] vm;
	psw_retained_t r_in, r_out;
	psw_state_t state;
	int miscompares, checked;
	psw_keypad_model i_kbd (.mclk(mclk), .cmd(cmd), .use_remote(use_remote), .keypad_keys(kk), .remote_keys(rk));
	persistent_switch_sequencer #(.TICK_CYCLES_P(10), .MISMATCH_S(15)) i_dut (.mclk(mclk), .rst(rst),
		.keypad_keys(kk), .remote_keys(rk), .switch_heat_duration(heat_s), .switch_cool_duration(cool_s),
		.switch_supply_ramp_rate(rate), .holding_at_target(hold), .magnet_current_ma(mag_i),
		.supply_current_ma(sup_i), .magnet_voltage(vm), .ramp_request(rreq), .retained_in(r_in),
		.retained_out(r_out), .retained_write(r_wr), .ramp_enable(r_en), .ramp_target_ma(tgt), .ramp_rate(r_rate),
		.ramp_request_granted(gnt), .state(state), .heater_on(heat), .persistent_indicator(ind),
		.persistent_mode(pmode), .seconds_left(secs), .switch_lock_error(lock), .current_mismatch(mism),
		.alert_pulse(alert), .prompt_enter(prm));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// supply steps toward the target at the commanded rate and stops on it
	always @(posedge mclk) begin
		if (r_en && sup_i > tgt) begin
			sup_i <= (sup_i - tgt > r_rate) ? sup_i - r_rate : tgt;
		end else if (r_en && sup_i < tgt) begin
			sup_i <= (tgt - sup_i > r_rate) ? sup_i + r_rate : tgt;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic stop_test();
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_st(input psw_state_t s);
		int n;
		n = 0;
		while (state !== s && n < 400) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (state !== s) begin
			$display("[FAIL] state expected %h seen %h", s, state);
			miscompares++;
			stop_test();
		end
	endtask
	task automatic press(input logic [3:0] k, input logic remote);
		@(posedge mclk);
		cmd <= k;
		use_remote <= remote;
		@(posedge mclk);
		cmd <= '0;
	endtask
	task automatic do_reset(input psw_retained_t r);
		@(posedge mclk);
		rst <= 1'b1;
		r_in <= r;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_heat();
		press(K_SW, 1'b0);
		wait_st(ST_HEATING);
		chk("heater", heat, 1);
		chk("grant", gnt, 0);
		press(K_SW, 1'b0);
		@(posedge mclk);
		#1 chk("state", state, ST_HEATING);
		wait_st(ST_PAUSED);
		chk("heater", heat, 1);
	endtask
	task automatic t_enter();
		press(K_SW, 1'b0);
		wait_st(ST_CONFIRM_ENTER);
		press(K_ES, 1'b0);
		wait_st(ST_PAUSED);
		press(K_SW, 1'b0);
		wait_st(ST_CONFIRM_ENTER);
		chk("prompt", prm, 1);
		chk("grant", gnt, 1);
		chk("rate", r_rate, rate);
		press(K_EN, 1'b0);
		wait_st(ST_COOLING);
		chk("secs", secs, cool_s);
		wait_st(ST_RAMP_ZERO);
		chk("indicator", ind, 1);
		wait_st(ST_PERSIST);
		chk("pmode", pmode, 1);
		chk("write", r_wr, 1);
		chk("cooled", r_out.cooled_ma, 24'h0000c8);
	endtask
	task automatic t_exit();
		press(K_SW, 1'b1);
		wait_st(ST_CONFIRM_EXIT);
		press(K_ES, 1'b1);
		wait_st(ST_PERSIST);
		press(K_SW, 1'b1);
		wait_st(ST_CONFIRM_EXIT);
		press(K_SW, 1'b1);
		wait_st(ST_RAMP_MATCH);
		chk("target", tgt, 24'h0000c8);
		wait_st(ST_EXIT_HEAT);
		chk("heater", heat, 1);
		chk("secs", secs, heat_s);
		vm <= 16'h0258;
		repeat (2) @(posedge mclk);
		#1 chk("mismatch", mism, 1);
		vm <= '0;
		wait_st(ST_EXIT_DONE);
		press(K_EN, 1'b0);
		wait_st(ST_PAUSED);
		chk("heater", heat, 1);
		chk("mismatch", mism, 1);
		repeat (170) @(posedge mclk);
		#1 chk("mismatch", mism, 0);
	endtask
	task automatic t_fault();
		mag_i <= 24'h000028;
		press(K_SW, 1'b0);
		wait_st(ST_CONFIRM_ENTER);
		press(K_EN, 1'b0);
		wait_st(ST_COOLING);
		vm <= 16'h0258;
		wait_st(ST_FAULT_MATCH);
		chk("indicator", ind, 0);
		chk("alert", alert, 1);
		chk("ramp", r_en, 0);
		vm <= '0;
		wait_st(ST_LOCK_HEAT);
		chk("lock", lock, 1);
		wait_st(ST_PAUSED_ERR);
		press(K_EN, 1'b0);
		wait_st(ST_PAUSED);
		press(K_SH, 1'b0);
		repeat (3) @(posedge mclk);
		#1 chk("heater", heat, 0);
		chk("grant", gnt, 0);
		wait_st(ST_PAUSED);
		chk("ramp", r_en, 0);
	endtask
	task automatic t_powerup();
		do_reset('{1'b1, 1'b1, 24'h0000c8});
		wait_st(ST_POWERUP_PROMPT);
		chk("heater", heat, 1);
		chk("prompt", prm, 1);
		press(K_EN, 1'b1);
		wait_st(ST_PERSIST);
		chk("pmode", pmode, 1);
		chk("indicator", ind, 1);
		chk("cooled", r_out.cooled_ma, 24'h0000c8);
		press(K_SW, 1'b0);
		wait_st(ST_CONFIRM_EXIT);
		press(K_EN, 1'b0);
		wait_st(ST_RAMP_MATCH);
		chk("target", tgt, 24'h0000c8);
		wait_st(ST_EXIT_DONE);
		chk("prompt", prm, 1);
		press(K_EN, 1'b0);
		wait_st(ST_PAUSED);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		miscompares = 0;
		checked = 0;
		rst = 1'b1;
		cmd = '0;
		use_remote = 1'b0;
		heat_s = 16'h0003;
		cool_s = 16'h0002;
		rate = 24'h000032;
		hold = 1'b1;
		rreq = 1'b1;
		mag_i = 24'h0000c8;
		sup_i = 24'h0000c8;
		vm = '0;
		r_in = '0;
		do_reset('0);
		t_heat();
		t_enter();
		t_exit();
		t_fault();
		t_powerup();
		stop_test();
	end
endmodule
`default_nettype wire
